// file: src/timed_port_pkg.sv
// Shared constants and types for the timed I/O port and its clock blocks
package timed_port_pkg;

	localparam int          DATA_W      = 32;
	localparam int          COUNT_W     = 16;
	localparam int          NUM_CB      = 6;
	localparam int          CB_SEL_W    = 3;
	localparam int          DIV_W       = 8;
	localparam int          SLICE_W     = 6;
	localparam int          SYS_CLK_MHZ = 125;
	localparam int          REF_CLK_MHZ = 100;
	localparam int          FIFO_DEPTH  = 2;

	localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;
	localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
	localparam logic [DIV_W-1:0]   DIV_RST   = 8'h00;
	localparam logic [DIV_W-1:0]   DIV_ONE   = 8'h01;
	localparam logic [SLICE_W-1:0] SLICE_RST = 6'h00;
	localparam logic [SLICE_W-1:0] SLICE_ONE = 6'h01;

	typedef enum logic [2:0]
	{
		WIDTH_1,
		WIDTH_4,
		WIDTH_8,
		WIDTH_16,
		WIDTH_32
	} port_width_t;

	typedef enum logic [2:0]
	{
		OP_OUT,
		OP_IN,
		OP_SET_TIME,
		OP_COND_EQ,
		OP_COND_NEQ,
		OP_GET_COUNT,
		OP_GET_STAMP
	} port_op_t;

	typedef enum logic [1:0]
	{
		COND_NONE,
		COND_EQ,
		COND_NEQ
	} cond_mode_t;

endpackage

// file: src/clock_block.sv
// One clock block: internal or 1-bit-port source, optional divide, tick output
`timescale 1ns/1ps
`default_nettype none

module clock_block
	import timed_port_pkg::*;
(
	input  wire logic             clock_i,
	input  wire logic             rstn_i,
	input  wire logic             ext_sel_i,
	input  wire logic             ext_pin_i,
	input  wire logic [DIV_W-1:0] div_i,
	output logic                  tick_o
);

	logic             pin_prev_reg;
	logic             pin_prev_next;
	logic [DIV_W-1:0] div_cnt_reg;
	logic [DIV_W-1:0] div_cnt_next;
	logic             tick_reg;
	logic             tick_next;
	logic             src_event;

	////////////////////////////////////////////////////////////////////////////////
	// Source edge and divider
	always_comb
	begin
		pin_prev_next = ext_pin_i;
		src_event     = ext_sel_i ? (ext_pin_i && !pin_prev_reg) : 1'b1;
		div_cnt_next  = div_cnt_reg;
		tick_next     = 1'b0;
		if (src_event)
		begin
			if (div_i <= DIV_ONE)
			begin
				tick_next    = 1'b1;
				div_cnt_next = DIV_RST;
			end
			else if (div_cnt_reg >= div_i - DIV_ONE)
			begin
				tick_next    = 1'b1;
				div_cnt_next = DIV_RST;
			end
			else
			begin
				div_cnt_next = div_cnt_reg + DIV_ONE;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pin_prev_reg <= 1'b0;
			div_cnt_reg  <= DIV_RST;
			tick_reg     <= 1'b0;
		end
		else
		begin
			pin_prev_reg <= pin_prev_next;
			div_cnt_reg  <= div_cnt_next;
			tick_reg     <= tick_next;
		end
	end

	assign tick_o = tick_reg;

endmodule

`default_nettype wire

// file: src/timed_io_port.sv
// Timed I/O port with serializer, transfer buffer, counter and six clock blocks
`timescale 1ns/1ps
`default_nettype none

module timed_io_port
	import timed_port_pkg::*;
(
	input  wire logic                        clock_i,
	input  wire logic                        rstn_i,
	input  wire logic                        port_en_i,
	input  wire logic                        dir_out_i,
	input  wire logic                        open_drain_i,
	input  wire logic                        buffered_i,
	input  wire port_width_t                 width_i,
	input  wire logic [CB_SEL_W-1:0]         cb_sel_i,
	input  wire logic [NUM_CB-2:0]           cb_ext_sel_i,
	input  wire logic [NUM_CB-2:0][DIV_W-1:0] cb_div_i,
	input  wire logic                        ext_clk_pin_i,
	input  wire logic [DATA_W-1:0]           link_pins_i,
	input  wire logic [DATA_W-1:0]           narrow_claim_i,
	input  wire logic                        core_valid_i,
	input  wire port_op_t                    core_op_i,
	input  wire logic [DATA_W-1:0]           core_wdata_i,
	output logic                             core_ready_o,
	output logic                             core_rvalid_o,
	output logic [DATA_W-1:0]                core_rdata_o,
	output logic                             cond_wait_o,
	input  wire logic [DATA_W-1:0]           pin_i,
	output logic [DATA_W-1:0]                pin_o,
	output logic [DATA_W-1:0]                pin_oe_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Clock blocks
	logic [NUM_CB-1:0] cb_tick;

	genvar k;
	generate
		for (k = 0; k < NUM_CB; k++)
		begin : g_cb
			if (k == 0)
			begin : g_ref
				clock_block u_cb
				(
					.clock_i   (clock_i),
					.rstn_i    (rstn_i),
					.ext_sel_i (1'b0),
					.ext_pin_i (ext_clk_pin_i),
					.div_i     (DIV_RST),
					.tick_o    (cb_tick[k])
				);
			end
			else
			begin : g_prog
				clock_block u_cb
				(
					.clock_i   (clock_i),
					.rstn_i    (rstn_i),
					.ext_sel_i (cb_ext_sel_i[k-1]),
					.ext_pin_i (ext_clk_pin_i),
					.div_i     (cb_div_i[k-1]),
					.tick_o    (cb_tick[k])
				);
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// State
	logic [DATA_W-1:0]  fifo_reg [FIFO_DEPTH];
	logic [DATA_W-1:0]  fifo_next [FIFO_DEPTH];
	logic               wr_ptr_reg, wr_ptr_next;
	logic               rd_ptr_reg, rd_ptr_next;
	logic [1:0]         fill_reg, fill_next;
	logic [DATA_W-1:0]  ser_reg, ser_next;
	logic [SLICE_W-1:0] ser_left_reg, ser_left_next;
	logic [DATA_W-1:0]  des_reg, des_next;
	logic [SLICE_W-1:0] des_cnt_reg, des_cnt_next;
	logic [DATA_W-1:0]  in_word_reg, in_word_next;
	logic               in_valid_reg, in_valid_next;
	logic [COUNT_W-1:0] count_reg, count_next;
	logic [COUNT_W-1:0] time_reg, time_next;
	logic               time_arm_reg, time_arm_next;
	logic [COUNT_W-1:0] stamp_reg, stamp_next;
	cond_mode_t         cond_reg, cond_next;
	logic [DATA_W-1:0]  cond_val_reg, cond_val_next;
	logic [DATA_W-1:0]  rdata_reg, rdata_next;
	logic               rvalid_reg, rvalid_next;

	logic [SLICE_W-1:0] w;
	logic [SLICE_W-1:0] nslices;
	logic [DATA_W-1:0]  wmask;
	logic [DATA_W-1:0]  avail;
	logic [DATA_W-1:0]  samp;
	logic [DATA_W-1:0]  insert;
	logic               tick;
	logic               time_ok;
	logic               cond_ok;
	logic               accept;
	logic               push;

	////////////////////////////////////////////////////////////////////////////////
	// Width decode and pin ownership
	always_comb
	begin
		unique case (width_i)
			WIDTH_1:  begin w = 6'h01; wmask = 32'h0000_0001; end
			WIDTH_4:  begin w = 6'h04; wmask = 32'h0000_000F; end
			WIDTH_8:  begin w = 6'h08; wmask = 32'h0000_00FF; end
			WIDTH_16: begin w = 6'h10; wmask = 32'h0000_FFFF; end
			default:  begin w = 6'h20; wmask = 32'hFFFF_FFFF; end
		endcase
		nslices = buffered_i ? SLICE_W'(DATA_W / int'(w)) : SLICE_ONE;
		avail   = wmask & ~link_pins_i & ~narrow_claim_i;
		samp    = pin_i & avail;
		insert  = (des_reg >> w) | (samp << (SLICE_W'(DATA_W) - w));
		tick    = port_en_i && (cb_sel_i < CB_SEL_W'(NUM_CB)) && cb_tick[cb_sel_i];
		time_ok = !time_arm_reg || (count_reg == time_reg);
		unique case (cond_reg)
			COND_EQ:  cond_ok = (samp == (cond_val_reg & avail));
			COND_NEQ: cond_ok = (samp != (cond_val_reg & avail));
			default:  cond_ok = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Core access: OP_OUT waits for buffer space with dir_out_i high, OP_IN for a received word with dir_out_i low, other ops accepted at once
	always_comb
	begin
		unique case (core_op_i)
			OP_OUT:  core_ready_o = (fill_reg < 2'(FIFO_DEPTH)) && dir_out_i;
			OP_IN:   core_ready_o = in_valid_reg && !dir_out_i;
			default: core_ready_o = 1'b1;
		endcase
		accept = core_valid_i && core_ready_o;
		push   = accept && (core_op_i == OP_OUT);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		fifo_next     = fifo_reg;
		wr_ptr_next   = wr_ptr_reg;
		rd_ptr_next   = rd_ptr_reg;
		fill_next     = fill_reg;
		ser_next      = ser_reg;
		ser_left_next = ser_left_reg;
		des_next      = des_reg;
		des_cnt_next  = des_cnt_reg;
		in_word_next  = in_word_reg;
		in_valid_next = in_valid_reg;
		count_next    = count_reg;
		time_next     = time_reg;
		time_arm_next = time_arm_reg;
		stamp_next    = stamp_reg;
		cond_next     = cond_reg;
		cond_val_next = cond_val_reg;
		rdata_next    = rdata_reg;
		rvalid_next   = 1'b0;

		// Core side
		if (accept)
		begin
			unique case (core_op_i)
				OP_OUT:
				begin
					fifo_next[wr_ptr_reg] = core_wdata_i;
					wr_ptr_next           = !wr_ptr_reg;
				end
				OP_IN:
				begin
					in_valid_next = 1'b0;
					rdata_next    = in_word_reg;
					rvalid_next   = 1'b1;
				end
				OP_SET_TIME:
				begin
					time_next     = core_wdata_i[COUNT_W-1:0];
					time_arm_next = 1'b1;
				end
				OP_COND_EQ:
				begin
					cond_next     = COND_EQ;
					cond_val_next = core_wdata_i;
				end
				OP_COND_NEQ:
				begin
					cond_next     = COND_NEQ;
					cond_val_next = core_wdata_i;
				end
				OP_GET_COUNT:
				begin
					rdata_next  = {16'h0000, count_reg};
					rvalid_next = 1'b1;
				end
				default:
				begin
					rdata_next  = {16'h0000, stamp_reg};
					rvalid_next = 1'b1;
				end
			endcase
		end

		if (tick)
		begin
			count_next = count_reg + COUNT_ONE;
			if (dir_out_i)
			begin
				// Serializer: shift out remaining slices, else load next word
				if (ser_left_reg > SLICE_ONE)
				begin
					ser_next      = ser_reg >> w;
					ser_left_next = ser_left_reg - SLICE_ONE;
				end
				else if ((fill_reg != 2'h0) && time_ok)
				begin
					ser_next      = fifo_reg[rd_ptr_reg];
					ser_left_next = nslices;
					rd_ptr_next   = !rd_ptr_reg;
					stamp_next    = count_reg;
					time_arm_next = 1'b0;
				end
				else
				begin
					ser_left_next = SLICE_RST;
				end
			end
			else if (des_cnt_reg == SLICE_RST)
			begin
				// Deserializer: first slice waits for time and condition
				if (!in_valid_next && time_ok && cond_ok)
				begin
					stamp_next    = count_reg;
					time_arm_next = 1'b0;
					cond_next     = COND_NONE;
					if (nslices == SLICE_ONE)
					begin
						in_word_next  = samp;
						in_valid_next = 1'b1;
					end
					else
					begin
						des_next     = insert;
						des_cnt_next = SLICE_ONE;
					end
				end
			end
			else
			begin
				des_next = insert;
				if (des_cnt_reg + SLICE_ONE == nslices)
				begin
					in_word_next  = insert;
					in_valid_next = 1'b1;
					des_cnt_next  = SLICE_RST;
				end
				else
				begin
					des_cnt_next = des_cnt_reg + SLICE_ONE;
				end
			end
		end

		fill_next = fill_reg + 2'(push) - 2'(rd_ptr_next != rd_ptr_reg);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			fifo_reg[0]  <= DATA_RST;
			fifo_reg[1]  <= DATA_RST;
			wr_ptr_reg   <= 1'b0;
			rd_ptr_reg   <= 1'b0;
			fill_reg     <= 2'h0;
			ser_reg      <= DATA_RST;
			ser_left_reg <= SLICE_RST;
			des_reg      <= DATA_RST;
			des_cnt_reg  <= SLICE_RST;
			in_word_reg  <= DATA_RST;
			in_valid_reg <= 1'b0;
			count_reg    <= COUNT_RST;
			time_reg     <= COUNT_RST;
			time_arm_reg <= 1'b0;
			stamp_reg    <= COUNT_RST;
			cond_reg     <= COND_NONE;
			cond_val_reg <= DATA_RST;
			rdata_reg    <= DATA_RST;
			rvalid_reg   <= 1'b0;
		end
		else
		begin
			fifo_reg     <= fifo_next;
			wr_ptr_reg   <= wr_ptr_next;
			rd_ptr_reg   <= rd_ptr_next;
			fill_reg     <= fill_next;
			ser_reg      <= ser_next;
			ser_left_reg <= ser_left_next;
			des_reg      <= des_next;
			des_cnt_reg  <= des_cnt_next;
			in_word_reg  <= in_word_next;
			in_valid_reg <= in_valid_next;
			count_reg    <= count_next;
			time_reg     <= time_next;
			time_arm_reg <= time_arm_next;
			stamp_reg    <= stamp_next;
			cond_reg     <= cond_next;
			cond_val_reg <= cond_val_next;
			rdata_reg    <= rdata_next;
			rvalid_reg   <= rvalid_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drive
	always_comb
	begin
		if (port_en_i && dir_out_i)
		begin
			if (open_drain_i)
			begin
				pin_o    = DATA_RST;
				pin_oe_o = ~ser_reg & avail;
			end
			else
			begin
				pin_o    = ser_reg & avail;
				pin_oe_o = avail;
			end
		end
		else
		begin
			pin_o    = DATA_RST;
			pin_oe_o = DATA_RST;
		end
	end

	assign core_rvalid_o = rvalid_reg;
	assign core_rdata_o  = rdata_reg;
	assign cond_wait_o   = (cond_reg != COND_NONE) && !dir_out_i;

endmodule

`default_nettype wire

// file: testbench/port_props.sv
// Concurrent checks on the timed port's core and pin ports
`timescale 1ns/1ps
`default_nettype none

module port_props
	import timed_port_pkg::*;
(
	input wire logic                clock_i,
	input wire logic                rstn_i,
	input wire logic                port_en_i,
	input wire logic                dir_out_i,
	input wire logic                open_drain_i,
	input wire logic [CB_SEL_W-1:0] cb_sel_i,
	input wire logic [DATA_W-1:0]   link_pins_i,
	input wire logic [DATA_W-1:0]   narrow_claim_i,
	input wire logic                core_valid_i,
	input wire port_op_t            core_op_i,
	input wire logic                core_ready_o,
	input wire logic                core_rvalid_o,
	input wire logic [DATA_W-1:0]   core_rdata_o,
	input wire logic                cond_wait_o,
	input wire logic [DATA_W-1:0]   pin_o,
	input wire logic [DATA_W-1:0]   pin_oe_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	wire rd_take = core_valid_i && core_ready_o
		&& (core_op_i inside {OP_IN, OP_GET_COUNT, OP_GET_STAMP});

	sequence count_read;
		core_valid_i && core_op_i == OP_GET_COUNT && port_en_i && cb_sel_i == 3'h0;
	endsequence
	sequence count_pair;
		count_read ##1 count_read;
	endsequence

	////////////////////////////////////////////////////////////
	chk_dir_refuse:
	assert property ((core_op_i == OP_OUT && !dir_out_i) || (core_op_i == OP_IN && dir_out_i)
		|-> !core_ready_o) else $error("ready against direction");
	chk_input_quiet:
	assert property (!dir_out_i [*3] |-> pin_oe_o == '0) else $error("input port drives");
	chk_od_low_only:
	assert property (open_drain_i [*2] |-> pin_o == '0) else $error("open drain drives high");
	chk_link_free:
	assert property ($stable(link_pins_i) |-> (pin_oe_o & link_pins_i) == '0)
		else $error("link pin driven");
	chk_narrow_free:
	assert property ($stable(narrow_claim_i) |-> (pin_oe_o & narrow_claim_i) == '0)
		else $error("claimed pin driven");
	chk_read_answer:
	assert property (rd_take |=> core_rvalid_o) else $error("read unanswered");
	chk_stray_answer:
	assert property (core_rvalid_o |-> $past(rd_take)) else $error("answer without read");
	chk_count_step:
	assert property (count_pair |=> core_rdata_o[COUNT_W-1:0]
		== $past(core_rdata_o[COUNT_W-1:0]) + COUNT_ONE) else $error("count step wrong");
	chk_cond_input:
	assert property (cond_wait_o |-> !dir_out_i) else $error("wait flagged on output");
	chk_off_quiet:
	assert property (!port_en_i [*3] |-> pin_oe_o == '0) else $error("disabled port drives");
endmodule

bind timed_io_port port_props u_props (.clock_i, .rstn_i, .port_en_i, .dir_out_i,
	.open_drain_i, .cb_sel_i, .link_pins_i, .narrow_claim_i, .core_valid_i, .core_op_i,
	.core_ready_o, .core_rvalid_o, .core_rdata_o, .cond_wait_o, .pin_o, .pin_oe_o);
`default_nettype wire

// file: testbench/pin_partner.sv
// Far-side pin model: pin levels and an external application clock
`timescale 1ns/1ps
`default_nettype none

module pin_partner
	import timed_port_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic [DATA_W-1:0] dev_pin_i,
	input  wire logic [DATA_W-1:0] dev_oe_i,
	input  wire logic [DATA_W-1:0] drive_i,
	input  wire logic [7:0]        half_i,
	output logic      [DATA_W-1:0] level_o,
	output logic                   app_clk_o
);
	logic [7:0] cnt = 8'h00;
	logic       app_clk = 1'b0;

	// Device drives where enabled, far side elsewhere
	assign level_o = (dev_oe_i & dev_pin_i) | (~dev_oe_i & drive_i);

	assign app_clk_o = app_clk;

	// Application clock, toggles every half_i cycles
	always @(posedge clock_i)
	begin
		if (cnt + 8'h01 >= half_i)
		begin
			cnt       <= 8'h00;
			app_clk   <= ~app_clk;
		end
		else
			cnt <= cnt + 8'h01;
	end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the timed I/O port
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import timed_port_pkg::*;
;
	logic            clock_i = 1'b0, rstn_i = 1'b0, en = 1'b0, dir = 1'b0;
	logic            od = 1'b0, bufd = 1'b0, valid = 1'b0;
	port_width_t     wid = WIDTH_8;
	port_op_t        opc = OP_OUT;
	logic [2:0]      cbs = 3'h0;
	logic [4:0]      exs = 5'h00;
	logic [4:0][7:0] divs = '0;
	logic [31:0]     link = '0, nar = '0, wd = '0, drv = '0, rdv;
	logic [15:0]     tm;
	wire  [31:0]     pin_in, pin_out, pin_oe, rdata;
	wire             ext_clk, ready, rvalid, cwait;
	int              mismatches = 0, checks = 0;
	port_width_t     wl[5] = '{WIDTH_1, WIDTH_4, WIDTH_8, WIDTH_16, WIDTH_32};
	logic [31:0]     ml[5] = '{32'h0000_0001, 32'h0000_000F, 32'h0000_00FF,
		32'h0000_FFFF, 32'hFFFF_FFFF};
	logic [15:0]     dl[3] = '{16'h0028, 16'h0004, 16'h0002};
	logic [7:0]      dv[3] = '{8'h00, 8'h00, 8'h02};

	initial
		forever #4 clock_i = ~clock_i;

	timed_io_port uut
	(
		.clock_i        (clock_i),
		.rstn_i         (rstn_i),
		.port_en_i      (en),
		.dir_out_i      (dir),
		.open_drain_i   (od),
		.buffered_i     (bufd),
		.width_i        (wid),
		.cb_sel_i       (cbs),
		.cb_ext_sel_i   (exs),
		.cb_div_i       (divs),
		.ext_clk_pin_i  (ext_clk),
		.link_pins_i    (link),
		.narrow_claim_i (nar),
		.core_valid_i   (valid),
		.core_op_i      (opc),
		.core_wdata_i   (wd),
		.core_ready_o   (ready),
		.core_rvalid_o  (rvalid),
		.core_rdata_o   (rdata),
		.cond_wait_o    (cwait),
		.pin_i          (pin_in),
		.pin_o          (pin_out),
		.pin_oe_o       (pin_oe)
	);

	pin_partner far
	(
		.clock_i   (clock_i),
		.dev_pin_i (pin_out),
		.dev_oe_i  (pin_oe),
		.drive_i   (drv),
		.half_i    (8'h05),
		.level_o   (pin_in),
		.app_clk_o (ext_clk)
	);

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic idle(input int n);
		valid <= 1'b0;
		repeat (n) @(posedge clock_i);
		@(negedge clock_i);
	endtask

	// Request held until taken at a rising edge with ready high
	task automatic op(input port_op_t o, input logic [31:0] d);
		int n;
		n = 0;
		if (!clock_i)
			@(posedge clock_i);
		valid <= 1'b1;
		opc <= o;
		wd <= d;
		@(negedge clock_i);
		while (ready !== 1'b1 && n < 100)
		begin
			n++;
			@(negedge clock_i);
		end
		chk(n < 100, 1'b1);
		@(posedge clock_i);
	endtask

	task automatic rd(input port_op_t o);
		op(o, 32'h0000_0000);
		valid <= 1'b0;
		@(negedge clock_i);
		chk(rvalid, 1'b1);
		rdv = rdata;
	endtask

	task automatic wait_pin(input logic [7:0] v);
		int n;
		n = 0;
		valid <= 1'b0;
		@(negedge clock_i);
		while (pin_out[7:0] !== v && n < 20)
		begin
			n++;
			@(negedge clock_i);
		end
		chk(n < 20, 1'b1);
	endtask

	task automatic cond_case(input port_op_t o, input logic [31:0] r, input logic [31:0] nv);
		idle(3);
		@(posedge clock_i);
		en <= 1'b0;
		rd(OP_IN);
		op(o, r);
		idle(1);
		chk(cwait, 1'b1);
		@(posedge clock_i);
		en <= 1'b1;
		idle(8);
		chk(cwait, 1'b1);
		@(posedge clock_i);
		drv <= nv;
		idle(1);
		chk(cwait, 1'b0);
		rd(OP_IN);
		chk(rdv, nv);
	endtask

	////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge clock_i);
		rstn_i <= 1'b1;
		@(negedge clock_i);
		chk(ready, 1'b0);
		chk(pin_oe, 32'h0000_0000);
		chk(rdata, 32'h0000_0000);
		@(posedge clock_i);
		en <= 1'b1;
		dir <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			wid <= wl[i];
			op(OP_OUT, 32'hA5C3_1E7F);
			idle(4);
			chk(pin_oe, ml[i]);
			chk(pin_out, 32'hA5C3_1E7F & ml[i]);
			@(posedge clock_i);
		end
		wid <= WIDTH_8;
		od <= 1'b1;
		op(OP_OUT, 32'h0000_000F);
		idle(4);
		chk(pin_out, 32'h0000_0000);
		chk(pin_oe, 32'h0000_00F0);
		@(posedge clock_i);
		od <= 1'b0;
		link <= 32'h0000_0003;
		nar <= 32'h0000_0030;
		op(OP_OUT, 32'h0000_00FF);
		idle(4);
		chk(pin_oe, 32'h0000_00CC);
		@(posedge clock_i);
		link <= 32'h0000_0000;
		nar <= 32'h0000_0000;
		bufd <= 1'b1;
		op(OP_OUT, 32'h4433_2211);
		wait_pin(8'h11);
		for (int k = 2; k < 5; k++)
		begin
			@(negedge clock_i);
			chk(pin_out[7:0], 8'h11 * k);
		end
		@(posedge clock_i);
		cbs <= 3'h7;
		op(OP_OUT, 32'h0102_0304);
		op(OP_OUT, 32'h0506_0708);
		@(negedge clock_i);
		chk(ready, 1'b0);
		@(posedge clock_i);
		cbs <= 3'h0;
		wait_pin(8'h05);
		idle(2);
		chk(ready, 1'b1);
		@(posedge clock_i);
		bufd <= 1'b0;
		rd(OP_GET_COUNT);
		tm = rdv[15:0] + 16'h003C;
		op(OP_SET_TIME, {16'h0000, tm});
		op(OP_OUT, 32'h0000_0066);
		idle(30);
		chk(pin_out[7:0], 8'h05);
		idle(40);
		chk(pin_out[7:0], 8'h66);
		rd(OP_GET_STAMP);
		chk(rdv, {16'h0000, tm});
		op(OP_GET_COUNT, 32'h0000_0000);
		op(OP_GET_COUNT, 32'h0000_0000);
		for (int i = 0; i < 3; i++)
		begin
			cbs <= (i > 0) ? 3'h1 : 3'h0;
			exs <= (i > 0) ? 5'h01 : 5'h00;
			divs[0] <= dv[i];
			idle(5);
			rd(OP_GET_COUNT);
			tm = rdv[15:0];
			idle(38);
			rd(OP_GET_COUNT);
			tm = rdv[15:0] - tm;
			chk(tm, dl[i]);
			@(posedge clock_i);
		end
		dir <= 1'b0;
		cbs <= 3'h0;
		wid <= WIDTH_32;
		cond_case(OP_COND_EQ, 32'h1234_5678, 32'h1234_5678);
		cond_case(OP_COND_NEQ, 32'h1234_5678, 32'h0F0F_0F0F);
		end_of_test();
	end

	// Cuts a hang short
	initial
	begin
		#200000;
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
